// *** design/lpc_pkg.sv ***
package lpc_pkg;
  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [4:0] LPC_CTRL_ADDR = 5'h17;
  localparam logic [4:0] LPC_STAT_ADDR = 5'h18;
  localparam logic [3:0] LPC_CTRL_RESET = 4'h0;
  localparam logic [2:0] LPC_STAT_RESET = 3'h0;
  localparam int LPC_FAST_BAUD_BIT = 0;
  localparam int LPC_DEBOUNCE_LSB = 1;
  localparam int LPC_WAKE_MODE_BIT = 3;
  localparam int LPC_WAKE_FLAG_BIT = 0;
  localparam int LPC_DTO_FLAG_BIT = 1;
  localparam int LPC_SHORT_FLAG_BIT = 2;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam logic [8:0] LPC_DEB_96 = 9'h060;
  localparam logic [8:0] LPC_DEB_128 = 9'h080;
  localparam logic [8:0] LPC_DEB_192 = 9'h0C0;
  localparam logic [8:0] LPC_DEB_255 = 9'h0FF;
  localparam logic [2:0] LPC_FAST_DIV_LAST = 3'h4;
  localparam int LPC_DTO_TIME_MS = 11;
  localparam int LPC_SLOW_OSC_KHZ = 32;
  localparam int LPC_FAST_OSC_KHZ = 1000;
  localparam int LPC_DTO_SLOW_TICKS = LPC_DTO_TIME_MS * LPC_SLOW_OSC_KHZ;
  localparam int LPC_DTO_FAST_TICKS = LPC_DTO_TIME_MS * LPC_FAST_OSC_KHZ;
  localparam int LPC_WAKE_SLOW_TICKS = 4;
  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef struct packed {
    logic wake_mode;
    logic [1:0] debounce_sel;
    logic fast_baud;
  } lpc_ctrl_t;
  typedef struct packed {
    logic short_flag;
    logic dom_timeout_flag;
    logic bus_wake_flag;
  } lpc_stat_t;
  typedef enum logic [1:0] {
    LPC_W_IDLE = 2'b00,
    LPC_W_DOM = 2'b01,
    LPC_W_RISE = 2'b10
  } lpc_wake_t;
endpackage

// *** design/lpc_tick_counter.sv ***
`timescale 1ns/10ps
module lpc_tick_counter
  import lpc_pkg::*;
#(
  parameter int W = 9
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic active,
  input wire logic tick,
  input wire logic [W-1:0] limit,
  output logic expired
);
  logic [W-1:0] count;

  // ----------------------------------------
  // saturating tick count while active
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
    end else if (!active) begin
      count <= '0;
    end else if (tick && count != {W{1'b1}}) begin
      count <= count + W'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      expired <= 1'b0;
    end else begin
      expired <= active && (count > limit);
    end
  end
endmodule // lpc_tick_counter

// *** design/lpc_protect.sv ***
`timescale 1ns/10ps
module lpc_protect
  import lpc_pkg::*;
#(
  parameter int DTO_SLOW_TICKS = LPC_DTO_SLOW_TICKS,
  parameter int DTO_FAST_TICKS = LPC_DTO_FAST_TICKS,
  parameter int WAKE_SLOW_TICKS = LPC_WAKE_SLOW_TICKS
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [4:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic slow_osc,
  input wire logic fast_osc,
  input wire logic sleep_mode,
  input wire logic watchdog_wake,
  input wire logic tx_data,
  input wire logic tx_stage_dom,
  input wire logic tx_overcurrent,
  input wire logic bus_rx,
  output logic tx_enable,
  output logic tx_drive_dom,
  output logic fast_baud_en,
  output logic wake_request
);
  lpc_ctrl_t ctrl;
  lpc_stat_t stat;
  lpc_wake_t wake_state;
  lpc_wake_t next_wake_state;
  logic slow_prev;
  logic fast_prev;
  logic rx_prev;
  logic [2:0] fast_div;
  logic slow_tick;
  logic fast_tick;
  logic div_tick;
  logic short_active;
  logic short_exp;
  logic dto_slow_exp;
  logic dto_fast_exp;
  logic dto_event;
  logic wake_dom_exp;
  logic wake_event;
  logic ctrl_wr;
  logic stat_wr;
  logic [8:0] short_limit;

  assign ctrl_wr = reg_wr && reg_addr == LPC_CTRL_ADDR;
  assign stat_wr = reg_wr && reg_addr == LPC_STAT_ADDR;

  // ----------------------------------------
  // oscillator ticks and fast/5 divider
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      slow_prev <= 1'b0;
      fast_prev <= 1'b0;
      rx_prev <= 1'b1;
    end else begin
      slow_prev <= slow_osc;
      fast_prev <= fast_osc;
      rx_prev <= bus_rx;
    end
  end

  assign slow_tick = slow_osc && !slow_prev;
  assign fast_tick = fast_osc && !fast_prev;
  assign div_tick = fast_tick && fast_div == LPC_FAST_DIV_LAST;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fast_div <= 3'h0;
    end else if (div_tick) begin
      fast_div <= 3'h0;
    end else if (fast_tick) begin
      fast_div <= fast_div + 3'h1;
    end
  end

  // ----------------------------------------
  // control register
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= LPC_CTRL_RESET;
    end else if (ctrl_wr) begin
      ctrl <= lpc_ctrl_t'(reg_wdata[3:0]);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fast_baud_en <= 1'b0;
    end else begin
      fast_baud_en <= ctrl.fast_baud;
    end
  end

  // ----------------------------------------
  // short detection
  // ----------------------------------------
  always_comb begin
    case (ctrl.debounce_sel)
      2'b00: short_limit = LPC_DEB_96;
      2'b01: short_limit = LPC_DEB_128;
      2'b10: short_limit = LPC_DEB_192;
      default: short_limit = LPC_DEB_255;
    endcase
  end

  // driving dominant, bus recessive, current over limit
  assign short_active = tx_enable && tx_drive_dom && bus_rx
    && tx_overcurrent;

  lpc_tick_counter #(.W(9)) u_short (
    .clk(clk),
    .rst_n(rst_n),
    .active(short_active),
    .tick(div_tick),
    .limit(short_limit),
    .expired(short_exp)
  );

  // ----------------------------------------
  // dominant time-out, two oscillators
  // ----------------------------------------
  // no enable term: always watching own stage
  lpc_tick_counter #(.W(16)) u_dto_slow (
    .clk(clk),
    .rst_n(rst_n),
    .active(tx_stage_dom),
    .tick(slow_tick),
    .limit(16'(DTO_SLOW_TICKS)),
    .expired(dto_slow_exp)
  );

  lpc_tick_counter #(.W(16)) u_dto_fast (
    .clk(clk),
    .rst_n(rst_n),
    .active(tx_stage_dom),
    .tick(fast_tick),
    .limit(16'(DTO_FAST_TICKS)),
    .expired(dto_fast_exp)
  );

  assign dto_event = dto_slow_exp || dto_fast_exp;

  // ----------------------------------------
  // wake-up detection
  // ----------------------------------------
  lpc_tick_counter #(.W(16)) u_wake (
    .clk(clk),
    .rst_n(rst_n),
    .active(wake_state == LPC_W_DOM && !bus_rx),
    .tick(slow_tick),
    .limit(16'(WAKE_SLOW_TICKS)),
    .expired(wake_dom_exp)
  );

  always_comb begin
    next_wake_state = wake_state;
    wake_event = 1'b0;
    case (wake_state)
      LPC_W_IDLE: begin
        if (sleep_mode && rx_prev && !bus_rx) begin
          next_wake_state = LPC_W_DOM;
        end
      end
      LPC_W_DOM: begin
        if (!sleep_mode || bus_rx) begin
          next_wake_state = LPC_W_IDLE;
        end else if (wake_dom_exp && ctrl.wake_mode) begin
          next_wake_state = LPC_W_RISE;
        end else if (wake_dom_exp) begin
          next_wake_state = LPC_W_IDLE;
          wake_event = 1'b1;
        end
      end
      LPC_W_RISE: begin
        if (!sleep_mode) begin
          next_wake_state = LPC_W_IDLE;
        end else if (bus_rx) begin
          next_wake_state = LPC_W_IDLE;
          wake_event = 1'b1;
        end
      end
      default: next_wake_state = LPC_W_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wake_state <= LPC_W_IDLE;
    end else begin
      wake_state <= next_wake_state;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wake_request <= 1'b0;
    end else begin
      wake_request <= wake_event;
    end
  end

  // ----------------------------------------
  // status flags, set beats clear
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stat <= LPC_STAT_RESET;
    end else begin
      if (short_exp) begin
        stat.short_flag <= 1'b1;
      end else if (stat_wr && reg_wdata[LPC_SHORT_FLAG_BIT]) begin
        stat.short_flag <= 1'b0;
      end
      if (dto_event) begin
        stat.dom_timeout_flag <= 1'b1;
      end else if (stat_wr && reg_wdata[LPC_DTO_FLAG_BIT]) begin
        stat.dom_timeout_flag <= 1'b0;
      end
      // watchdog wake never touches this flag
      if (wake_event) begin
        stat.bus_wake_flag <= 1'b1;
      end else if (stat_wr && reg_wdata[LPC_WAKE_FLAG_BIT]) begin
        stat.bus_wake_flag <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // transmitter power and drive
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_enable <= 1'b0;
      tx_drive_dom <= 1'b0;
    end else begin
      tx_enable <= !sleep_mode && !stat.short_flag
        && !stat.dom_timeout_flag && !short_exp && !dto_event;
      tx_drive_dom <= tx_enable && !tx_data && !short_exp && !dto_event;
    end
  end

  // ----------------------------------------
  // read data
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        LPC_CTRL_ADDR: reg_rdata <= {4'h0, ctrl};
        LPC_STAT_ADDR: reg_rdata <= {5'h00, stat};
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  dto_flag_set_a: assert property (@(posedge clk) disable iff (!rst_n)
    dto_event |=> stat.dom_timeout_flag)
    else $error("time-out did not set flag");
  dto_own_only_a: assert property (@(posedge clk) disable iff (!rst_n)
    !tx_stage_dom |=> !dto_event)
    else $error("time-out without own dominance");
  short_flag_set_a: assert property (@(posedge clk) disable iff (!rst_n)
    short_exp |=> stat.short_flag ##1 !tx_enable)
    else $error("short did not set flag and disable");
  fault_holds_off_a: assert property (@(posedge clk) disable iff (!rst_n)
    stat.short_flag || stat.dom_timeout_flag |=> !tx_enable)
    else $error("transmitter on during fault");
  w1c_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    stat_wr && reg_wdata[LPC_SHORT_FLAG_BIT] && !short_exp
    |=> !stat.short_flag)
    else $error("write one did not clear");
  zero_keeps_a: assert property (@(posedge clk) disable iff (!rst_n)
    stat.bus_wake_flag && !(stat_wr && reg_wdata[LPC_WAKE_FLAG_BIT])
    |=> stat.bus_wake_flag)
    else $error("flag lost without write one");
  wdt_no_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
    watchdog_wake && !wake_event && !stat.bus_wake_flag
    |=> !stat.bus_wake_flag)
    else $error("watchdog wake set bus flag");
  fast_baud_a: assert property (@(posedge clk) disable iff (!rst_n)
    ctrl_wr |=> ##1
    fast_baud_en == $past(reg_wdata[LPC_FAST_BAUD_BIT], 2))
    else $error("fast baud not following write");
  sleep_tx_off_a: assert property (@(posedge clk) disable iff (!rst_n)
    sleep_mode |=> !tx_enable ##1 !tx_drive_dom)
    else $error("transmitter powered in sleep");
  wake_mode_a: assert property (@(posedge clk) disable iff (!rst_n)
    wake_event && ctrl.wake_mode |-> wake_state == LPC_W_RISE
    && bus_rx)
    else $error("mode one wake without rising edge");
endmodule // lpc_protect

// *** bench/lpc_bus_node.sv ***
`timescale 1ns/10ps
// ----------------------------------------
// other bus nodes
// ----------------------------------------
module lpc_bus_node (
  input wire logic own_dom,
  input wire logic ext_dom,
  input wire logic shorted,
  output logic bus_rx
);
  // wired-and with pull-up, a short pins the line recessive
  assign bus_rx = shorted | ~(own_dom | ext_dom);
endmodule // lpc_bus_node

// *** bench/lpc_protect_bench.sv ***
`timescale 1ns/10ps
module lpc_protect_bench
  import lpc_pkg::*;
();
  // ----------------------------------------
  // stimulus and design
  // ----------------------------------------
  logic clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0;
  logic [4:0] reg_addr = 5'h00;
  logic [7:0] reg_wdata = 8'h00, reg_rdata;
  logic slow_osc = 0, fast_osc = 0, sleep_mode = 0, watchdog_wake = 0;
  logic tx_data = 1, tx_overcurrent = 0, ext_dom = 0, shorted = 0;
  logic fast_run = 1, slow_run = 1, tx_stage_dom, bus_rx;
  logic tx_enable, tx_drive_dom, fast_baud_en, wake_request;
  logic [2:0] sdiv = 3'h0;
  int error_cnt = 0, n_compared = 0, wake_cnt = 0, n, w0, lo, hi;
  logic [8:0] lim [4] = '{LPC_DEB_96, LPC_DEB_128, LPC_DEB_192, LPC_DEB_255};
  // sensed stage dominant unless the pin is shorted recessive
  assign tx_stage_dom = tx_enable & tx_drive_dom & ~shorted;
  lpc_protect #(.DTO_SLOW_TICKS(8), .DTO_FAST_TICKS(20),
    .WAKE_SLOW_TICKS(2)) DUT (.clk(clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .slow_osc(slow_osc),
    .fast_osc(fast_osc), .sleep_mode(sleep_mode),
    .watchdog_wake(watchdog_wake), .tx_data(tx_data),
    .tx_stage_dom(tx_stage_dom), .tx_overcurrent(tx_overcurrent),
    .bus_rx(bus_rx), .tx_enable(tx_enable), .tx_drive_dom(tx_drive_dom),
    .fast_baud_en(fast_baud_en), .wake_request(wake_request));
  lpc_bus_node partner (.own_dom(tx_stage_dom), .ext_dom(ext_dom),
    .shorted(shorted), .bus_rx(bus_rx));
  initial forever #50 clk = ~clk;
  always @(posedge clk) begin
    #10;
    if (fast_run) fast_osc = ~fast_osc;
    sdiv = sdiv + 3'h1;
    if (slow_run && sdiv == 3'h0) slow_osc = ~slow_osc;
  end
  always @(negedge clk) if (wake_request === 1'b1) wake_cnt++;
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(string what, logic [7:0] got, logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick(int c);
    repeat (c) @(posedge clk);
    #10;
  endtask
  task automatic wr(logic [4:0] a, logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1;
    tick(1);
    reg_wr = 0;
    tick(1);
  endtask
  task automatic rdc(string what, logic [4:0] a, logic [7:0] exp);
    reg_addr = a;
    reg_rd = 1;
    tick(1);
    reg_rd = 0;
    chk(what, reg_rdata, exp);
    tick(1);
  endtask
  task automatic wait_off(int l);
    n = 0;
    while (tx_enable !== 1'b0 && n < l) begin
      tick(1);
      n++;
    end
  endtask
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs();
    rdc("ctrl_rst", LPC_CTRL_ADDR, {4'h0, LPC_CTRL_RESET});
    rdc("stat_rst", LPC_STAT_ADDR, {5'h00, LPC_STAT_RESET});
    wr(LPC_CTRL_ADDR, 8'hFF);
    rdc("ctrl_rw", LPC_CTRL_ADDR, 8'h0F);
    chk("fast_on", fast_baud_en, 8'h01);
    wr(LPC_CTRL_ADDR, 8'h0E);
    chk("fast_off", fast_baud_en, 8'h00);
    wr(5'h05, 8'hFF);
    rdc("unmapped", 5'h05, 8'h00);
    wr(LPC_CTRL_ADDR, 8'h00);
  endtask
  task automatic t_ext();
    ext_dom = 1;
    tick(400);
    chk("ext_dom_tx", tx_enable, 8'h01);
    ext_dom = 0;
    rdc("ext_dom_st", LPC_STAT_ADDR, 8'h00);
  endtask
  task automatic t_dto();
    for (int k = 0; k < 3; k++) begin
      fast_run = (k != 2);
      slow_run = (k != 1);
      lo = (k == 2) ? 125 : 38;
      hi = (k == 2) ? 160 : 48;
      wr(LPC_CTRL_ADDR, (k == 0) ? 8'h0F : 8'h00);
      tx_data = 0;
      wait_off(400);
      chk("dto_time", {7'h00, n >= lo && n <= hi}, 8'h01);
      chk("dto_drive", tx_drive_dom, 8'h00);
      tx_data = 1;
      tick(20);
      chk("dto_hold", tx_enable, 8'h00);
      rdc("dto_flag", LPC_STAT_ADDR, 8'h02);
      wr(LPC_STAT_ADDR, 8'h02);
      chk("dto_back", tx_enable, 8'h01);
      rdc("dto_clr", LPC_STAT_ADDR, 8'h00);
    end
    fast_run = 1;
    slow_run = 1;
  endtask
  task automatic t_short();
    shorted = 1;
    for (int k = 0; k < 2; k++) begin
      tx_data = (k == 0);
      tx_overcurrent = (k == 0);
      tick(1100);
      chk("short_qual", tx_enable, 8'h01);
    end
    for (int s = 0; s < 4; s++) begin
      wr(LPC_CTRL_ADDR, 8'(s << LPC_DEBOUNCE_LSB));
      tx_data = 0;
      tx_overcurrent = 1;
      wait_off(3000);
      lo = int'(lim[s]) * 10;
      chk("short_time", {7'h00, n >= lo && n <= lo + 30}, 8'h01);
      shorted = 0;
      tx_overcurrent = 0;
      tx_data = 1;
      tick(20);
      chk("short_hold", tx_enable, 8'h00);
      rdc("short_flag", LPC_STAT_ADDR, 8'h04);
      wr(LPC_STAT_ADDR, 8'h03);
      rdc("keep_flag", LPC_STAT_ADDR, 8'h04);
      wr(LPC_STAT_ADDR, 8'h04);
      rdc("short_clr", LPC_STAT_ADDR, 8'h00);
      chk("short_back", tx_enable, 8'h01);
      shorted = 1;
    end
    shorted = 0;
  endtask
  task automatic t_wake();
    for (int m = 0; m < 2; m++) begin
      wr(LPC_CTRL_ADDR, 8'(m << LPC_WAKE_MODE_BIT));
      sleep_mode = 1;
      tick(2);
      chk("sleep_tx", tx_enable, 8'h00);
      ext_dom = 1;
      tick(12);
      ext_dom = 0;
      tick(40);
      rdc("wake_short", LPC_STAT_ADDR, 8'h00);
      w0 = wake_cnt;
      ext_dom = 1;
      tick(80);
      rdc("wake_edge", LPC_STAT_ADDR, (m == 0) ? 8'h01 : 8'h00);
      ext_dom = 0;
      tick(4);
      chk("wake_req", 8'(wake_cnt - w0), 8'h01);
      rdc("wake_flag", LPC_STAT_ADDR, 8'h01);
      sleep_mode = 0;
      tick(2);
      chk("wake_tx", tx_enable, 8'h01);
      wr(LPC_STAT_ADDR, 8'h01);
      rdc("wake_clr", LPC_STAT_ADDR, 8'h00);
    end
    sleep_mode = 1;
    tick(2);
    watchdog_wake = 1;
    tick(1);
    watchdog_wake = 0;
    sleep_mode = 0;
    tick(2);
    rdc("wdt_wake", LPC_STAT_ADDR, 8'h00);
  endtask
  initial begin
    #5000000;
    error_cnt++;
    finish_test();
  end
  initial begin
    repeat (12) @(posedge clk);
    #10;
    chk("tx_en_rst", tx_enable, 8'h00);
    rst_n = 1;
    tick(2);
    t_regs();
    t_ext();
    t_dto();
    t_short();
    t_wake();
    finish_test();
  end
endmodule // lpc_protect_bench
